// >>> core/ddac_slave.sv
`timescale 1ns/1ps
`include "ddac_regs.svh"
module ddac_slave #(
  parameter logic [4:0] ADDR_HI = `DDAC_ADDR_HI_RST,
  parameter bit HS_ENABLE = 1'b1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Two-wire bus pins.
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // Address strap pin.
  input wire ddac_pkg::ddac_pin_t addr_pin,
  // Decoded block stream.
  output logic blk_valid,
  output ddac_pkg::ddac_block_t blk_word,
  input wire logic blk_ready,
  // Status.
  output logic ref_enable,
  output logic hs_active
);
  import ddac_pkg::*;

  // ****************************************************************
  // Functions
  // ****************************************************************

  // Low address bits from the sensed strap level.
  function automatic logic [1:0] pin_bits(input ddac_pin_t p);
    case (p)
      DDAC_PIN_SUPPLY: pin_bits = 2'b00;
      DDAC_PIN_FLOAT: pin_bits = 2'b10;
      DDAC_PIN_GROUND: pin_bits = 2'b11;
      default: pin_bits = 2'b10;
    endcase
  endfunction

  // Channel mask from the channel field; bit 0 is A, bit 1 is B.
  function automatic logic [1:0] chan_decode(input logic [2:0] ch);
    case (ch)
      `DDAC_CH_A: chan_decode = 2'b01;
      `DDAC_CH_B: chan_decode = 2'b10;
      `DDAC_CH_BOTH: chan_decode = 2'b11;
      default: chan_decode = 2'b00;
    endcase
  endfunction

  // ****************************************************************
  // Input synchronisers and edge detection
  // ****************************************************************

  logic scl_m_r, scl_s_r, scl_d_r;
  logic sda_m_r, sda_s_r, sda_d_r;
  ddac_pin_t pin_m_r, pin_s_r;
  logic scl_rise, scl_fall, start_det, stop_det;

  // Two flops per pin, then one delay stage for edges.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_m_r <= scl_i;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= sda_i;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
    end
  end

  // Strap level is sampled continuously through its own synchroniser.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pin_m_r <= DDAC_PIN_FLOAT;
      pin_s_r <= DDAC_PIN_FLOAT;
    end
    else
    begin
      pin_m_r <= addr_pin;
      pin_s_r <= pin_m_r;
    end
  end

  // Start and stop are data edges while the clock stays high.
  assign scl_rise = scl_s_r & ~scl_d_r;
  assign scl_fall = ~scl_s_r & scl_d_r;
  assign start_det = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  assign stop_det = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

  // ****************************************************************
  // Serial engine
  // ****************************************************************

  ddac_state_t state_r;
  ddac_phase_t phase_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] rx_sh_r;
  logic [7:0] tx_sh_r;
  logic [23:0] isr_r;
  logic sticky_r, first_cmd_r, reading_r, tx_second_r, master_ack_r, push_pend_r;
  logic [6:0] own_addr;
  logic room, push;
  ddac_block_t new_blk;

  assign own_addr = {ADDR_HI, pin_bits(pin_s_r)};

  // Block pushed at the falling edge that ends its last acknowledge.
  assign push = (state_r == DDAC_ST_ACK) && scl_fall && push_pend_r;
  assign new_blk.op = ddac_op_t'(isr_r[16+`DDAC_OP_MSB:16+`DDAC_OP_LSB]);
  assign new_blk.chan_mask = chan_decode(isr_r[16+`DDAC_CH_MSB:16+`DDAC_CH_LSB]);
  assign new_blk.data = isr_r[15:0];

  // Bit and byte framing, acknowledge and readback.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_r <= DDAC_ST_IDLE;
      phase_r <= DDAC_PH_ADDR;
      bit_cnt_r <= 4'h0;
      rx_sh_r <= 8'h00;
      tx_sh_r <= 8'h00;
      isr_r <= 24'h000000;
      sticky_r <= 1'b0;
      first_cmd_r <= 1'b0;
      reading_r <= 1'b0;
      tx_second_r <= 1'b0;
      master_ack_r <= 1'b0;
      push_pend_r <= 1'b0;
      sda_oe_n <= 1'b1;
    end
    else if (stop_det)
    begin
      state_r <= DDAC_ST_IDLE;
      push_pend_r <= 1'b0;
      sda_oe_n <= 1'b1;
    end
    else if (start_det)
    begin
      state_r <= DDAC_ST_RX;
      phase_r <= DDAC_PH_ADDR;
      bit_cnt_r <= 4'h0;
      first_cmd_r <= 1'b1;
      sticky_r <= 1'b0;
      push_pend_r <= 1'b0;
      sda_oe_n <= 1'b1;
    end
    else
    begin
      case (state_r)
        DDAC_ST_RX:
        begin
          if (scl_rise && bit_cnt_r != `DDAC_BYTE_BITS)
          begin
            rx_sh_r <= {rx_sh_r[6:0], sda_s_r};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
          else if (scl_fall && bit_cnt_r == `DDAC_BYTE_BITS)
          begin
            bit_cnt_r <= 4'h0;
            state_r <= DDAC_ST_ACK;
            sda_oe_n <= 1'b0;
            case (phase_r)
              DDAC_PH_ADDR:
              begin
                reading_r <= rx_sh_r[0];
                if (rx_sh_r[7:1] == own_addr)
                  phase_r <= DDAC_PH_CMD;
                else if (rx_sh_r[7:1] == `DDAC_BCAST_ADDR && !rx_sh_r[0])
                  phase_r <= DDAC_PH_CMD;
                else
                begin
                  state_r <= DDAC_ST_WAIT;
                  sda_oe_n <= 1'b1;
                end
              end
              DDAC_PH_CMD:
              begin
                isr_r[23:16] <= rx_sh_r;
                phase_r <= DDAC_PH_HI;
                if (first_cmd_r)
                  sticky_r <= rx_sh_r[`DDAC_STICKY_BIT];
                first_cmd_r <= 1'b0;
              end
              DDAC_PH_HI:
              begin
                isr_r[15:8] <= rx_sh_r;
                phase_r <= DDAC_PH_LO;
              end
              default:
              begin
                isr_r[7:0] <= rx_sh_r;
                phase_r <= sticky_r ? DDAC_PH_HI : DDAC_PH_CMD;
                push_pend_r <= room;
                if (!room)
                begin
                  state_r <= DDAC_ST_WAIT;
                  sda_oe_n <= 1'b1;
                end
              end
            endcase
          end
        end
        DDAC_ST_ACK:
        begin
          if (scl_fall)
          begin
            push_pend_r <= 1'b0;
            if (reading_r)
            begin
              state_r <= DDAC_ST_TX;
              sda_oe_n <= isr_r[15];
              tx_sh_r <= {isr_r[14:8], 1'b0};
              tx_second_r <= 1'b0;
            end
            else
            begin
              state_r <= DDAC_ST_RX;
              sda_oe_n <= 1'b1;
            end
          end
        end
        DDAC_ST_TX:
        begin
          if (scl_rise)
            bit_cnt_r <= bit_cnt_r + 4'h1;
          else if (scl_fall && bit_cnt_r == `DDAC_BYTE_BITS)
          begin
            bit_cnt_r <= 4'h0;
            sda_oe_n <= 1'b1;
            state_r <= DDAC_ST_TXACK;
          end
          else if (scl_fall)
          begin
            sda_oe_n <= tx_sh_r[7];
            tx_sh_r <= {tx_sh_r[6:0], 1'b0};
          end
        end
        DDAC_ST_TXACK:
        begin
          if (scl_rise)
            master_ack_r <= ~sda_s_r;
          else if (scl_fall)
          begin
            if (master_ack_r && !tx_second_r)
            begin
              state_r <= DDAC_ST_TX;
              tx_second_r <= 1'b1;
              sda_oe_n <= isr_r[7];
              tx_sh_r <= {isr_r[6:0], 1'b0};
            end
            else
              state_r <= DDAC_ST_WAIT;
          end
        end
        default:
          sda_oe_n <= 1'b1;
      endcase
    end
  end

  // The bus is open drain: only a low level is ever driven.
  always_ff @(posedge clk)
  begin
    sda_o <= 1'b0;
  end

  // ****************************************************************
  // High-speed mode tracking
  // ****************************************************************

  // Set by the master code, held through repeated starts, cleared by stop.
  always_ff @(posedge clk)
  begin
    if (reset)
      hs_active <= 1'b0;
    else if (stop_det)
      hs_active <= 1'b0;
    else if (HS_ENABLE && state_r == DDAC_ST_RX && phase_r == DDAC_PH_ADDR && scl_fall
             && bit_cnt_r == `DDAC_BYTE_BITS && rx_sh_r[7:3] == `DDAC_HS_CODE)
      hs_active <= 1'b1;
  end

  // ****************************************************************
  // Reference control
  // ****************************************************************

  // Reference is off from reset and follows the reference command's bit 0.
  always_ff @(posedge clk)
  begin
    if (reset)
      ref_enable <= 1'b0;
    else if (push && new_blk.op == DDAC_OP_REF)
      ref_enable <= new_blk.data[0];
  end

  // ****************************************************************
  // Two-entry output buffer
  // ****************************************************************

  ddac_block_t spare_r;
  logic spare_v_r, pop;

  assign pop = blk_valid & blk_ready;
  // A full buffer makes the last data byte go unacknowledged and the block is dropped.
  assign room = ~spare_v_r;

  // Head register drives the port; the spare catches a block during a stall.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      blk_valid <= 1'b0;
      blk_word <= '0;
      spare_r <= '0;
      spare_v_r <= 1'b0;
    end
    else
    begin
      if (pop)
      begin
        if (spare_v_r)
        begin
          blk_word <= spare_r;
          spare_v_r <= 1'b0;
        end
        else
          blk_valid <= 1'b0;
      end
      if (push)
      begin
        if (!blk_valid || (pop && !spare_v_r))
        begin
          blk_word <= new_blk;
          blk_valid <= 1'b1;
        end
        else
        begin
          spare_r <= new_blk;
          spare_v_r <= 1'b1;
        end
      end
    end
  end
endmodule

// >>> core/ddac_regs.svh
`ifndef DDAC_REGS_SVH
`define DDAC_REGS_SVH
`define DDAC_BCAST_ADDR 7'h08
`define DDAC_HS_CODE 5'h01
`define DDAC_STICKY_BIT 6
`define DDAC_OP_MSB 5
`define DDAC_OP_LSB 3
`define DDAC_CH_MSB 2
`define DDAC_CH_LSB 0
`define DDAC_BYTE_BITS 4'h8
`define DDAC_CH_A 3'h0
`define DDAC_CH_B 3'h1
`define DDAC_CH_BOTH 3'h7
`define DDAC_ADDR_HI_RST 5'h0f
`endif

// >>> core/ddac_pkg.sv
package ddac_pkg;
  // Command codes of the command byte.
  typedef enum logic [2:0] {
    DDAC_OP_WR_INPUT = 3'b000,
    DDAC_OP_UPDATE = 3'b001,
    DDAC_OP_WR_UPD_ALL = 3'b010,
    DDAC_OP_WR_UPD = 3'b011,
    DDAC_OP_POWER = 3'b100,
    DDAC_OP_RESET = 3'b101,
    DDAC_OP_LOAD_MASK = 3'b110,
    DDAC_OP_REF = 3'b111
  } ddac_op_t;
  // Sensed level of the three-state address pin.
  typedef enum logic [1:0] {
    DDAC_PIN_SUPPLY = 2'b00,
    DDAC_PIN_FLOAT = 2'b01,
    DDAC_PIN_GROUND = 2'b10
  } ddac_pin_t;
  // Serial engine states.
  typedef enum logic [2:0] {
    DDAC_ST_IDLE = 3'b000,
    DDAC_ST_RX = 3'b001,
    DDAC_ST_ACK = 3'b010,
    DDAC_ST_TX = 3'b011,
    DDAC_ST_TXACK = 3'b100,
    DDAC_ST_WAIT = 3'b101
  } ddac_state_t;
  // Which byte of the write is expected next.
  typedef enum logic [1:0] {
    DDAC_PH_ADDR = 2'b00,
    DDAC_PH_CMD = 2'b01,
    DDAC_PH_HI = 2'b10,
    DDAC_PH_LO = 2'b11
  } ddac_phase_t;
  // One decoded block handed to the DAC core.
  typedef struct packed {
    ddac_op_t op;
    logic [1:0] chan_mask;
    logic [15:0] data;
  } ddac_block_t;
endpackage

// >>> tb/ddac_master_model.sv
`timescale 1ns/1ps
// ****
// Bus master
// ****
module ddac_master_model (
  // Bench clock.
  input wire logic clk,
  // Bus lines, idle high.
  output logic scl = 1'b1,
  output logic sda_drv = 1'b1,
  input wire logic sda
);
  // Waits n falling clock edges.
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Start or repeated start.
  task automatic start();
    sda_drv = 1'b1;
    hold(2);
    scl = 1'b1;
    hold(2);
    sda_drv = 1'b0;
    hold(2);
    scl = 1'b0;
    hold(2);
  endtask
  // Stop after the last bit.
  task automatic stop();
    sda_drv = 1'b0;
    hold(2);
    scl = 1'b1;
    hold(2);
    sda_drv = 1'b1;
    hold(4);
  endtask
  // One bit: data set in the low half, sampled late in the high half.
  task automatic bit_io(input logic b, output logic s);
    sda_drv = b;
    hold(2);
    scl = 1'b1;
    hold(3);
    s = sda;
    hold(1);
    scl = 1'b0;
    hold(2);
  endtask
  // Byte out, first bit the top one, then the acknowledge slot.
  task automatic put_byte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(v[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask
  // Byte in, then our acknowledge or not.
  task automatic get_byte(input logic ack_it, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, v[i]);
    bit_io(!ack_it, s);
  endtask
endmodule

// >>> tb/ddac_assertions.sv
`timescale 1ns/1ps
// ****
// Port checker
// ****
module ddac_chk #(
  parameter logic [4:0] ADDR_HI = 5'h0f,
  parameter bit HS_ENABLE = 1'b1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Bus pins.
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n,
  // Strap, stream and status.
  input wire ddac_pkg::ddac_pin_t addr_pin,
  input wire logic blk_valid,
  input wire ddac_pkg::ddac_block_t blk_word,
  input wire logic blk_ready,
  input wire logic ref_enable,
  input wire logic hs_active
);
  import ddac_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // Stop seen on the pins.
  sequence stop_s;
    scl_i && $past(scl_i) && sda_i && !$past(sda_i);
  endsequence
  // Output checks.
  a_reset_quiet: assert property (disable iff (1'b0) reset |=> sda_oe_n && !blk_valid
    && blk_word == '0 && !ref_enable && !hs_active) else $error("outputs not cleared");
  a_release_idle: assert property ($fell(reset) |-> sda_oe_n [*3])
    else $error("bus driven right after reset");
  a_drive_scl_low: assert property ($changed(sda_oe_n) |-> !$past(scl_i, 2))
    else $error("data drive changed while clock high");
  a_stop_release: assert property (stop_s |-> sda_oe_n [*4])
    else $error("bus driven after stop");
  a_hs_clear: assert property (stop_s |-> ##[1:8] !hs_active)
    else $error("fast mode kept after stop");
  a_hs_option: assert property ($rose(hs_active) |-> HS_ENABLE)
    else $error("fast mode without build option");
  a_blk_hold: assert property (blk_valid && !blk_ready |=> blk_valid && $stable(blk_word))
    else $error("block lost while stalled");
  a_sda_low_only: assert property (!sda_o)
    else $error("data pin driven high");
  // Main scenarios.
  c_take: cover property (blk_valid && blk_ready);
  c_ack: cover property ($fell(sda_oe_n));
  c_hs: cover property ($rose(hs_active));
endmodule
bind ddac_slave ddac_chk #(.ADDR_HI(ADDR_HI), .HS_ENABLE(HS_ENABLE)) ddac_chk_i (
  .clk(clk), .reset(reset), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_n(sda_oe_n), .addr_pin(addr_pin), .blk_valid(blk_valid), .blk_word(blk_word),
  .blk_ready(blk_ready), .ref_enable(ref_enable), .hs_active(hs_active));

// >>> tb/test_dual_dac_i2c_slave_command_port.sv
`timescale 1ns/1ps
// ****
// Bench top
// ****
module test_dual_dac_i2c_slave_command_port;
  import ddac_pkg::*;
  // Bench state and reference model state.
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic blk_ready = 1'b0;
  logic stall = 1'b1;
  logic exp_ref = 1'b0;
  logic exp_hs = 1'b0;
  logic take = 1'b0;
  logic scl, sda_drv, sda_o, sda_oe_n, blk_valid, ref_enable, hs_active, first, stk;
  logic [7:0] cmd, hd, lh, ll;
  logic [6:0] own;
  logic [31:0] rs = 32'h1727;
  ddac_pin_t pin = DDAC_PIN_SUPPLY;
  ddac_block_t blk_word;
  ddac_block_t exp_q[$];
  int fail_count = 0;
  int check_count = 0;
  int ph = 0;
  // The wire is low while either party pulls it.
  wire logic sda = sda_drv & sda_oe_n;
  ddac_slave #(.ADDR_HI(5'h0f), .HS_ENABLE(1'b1)) ddac_slave_i (.clk(clk), .reset(reset),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .addr_pin(pin),
    .blk_valid(blk_valid), .blk_word(blk_word), .blk_ready(blk_ready),
    .ref_enable(ref_enable), .hs_active(hs_active));
  ddac_master_model ddac_master_model_i (.clk(clk), .scl(scl), .sda_drv(sda_drv), .sda(sda));
  // Clock.
  always #20 clk = ~clk;
  // Random source.
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  // Channel code to channel mask.
  function automatic logic [1:0] msk(input logic [2:0] c);
    return c == 3'h0 ? 2'b01 : c == 3'h1 ? 2'b10 : c == 3'h7 ? 2'b11 : 2'b00;
  endfunction
  // Counts one comparison and reports a mismatch.
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (e !== g)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // Verdict and end of run.
  task automatic final_report();
    if (fail_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Consumer with random stalls; the stream holds still until the next rising edge,
  // so the block that this new ready will take is compared here, away from that edge.
  always @(negedge clk)
  begin
    take = !stall && (xs() & 32'h1) != 0;
    if (!reset && blk_valid && take)
      chk("block", exp_q.size() ? 32'(exp_q.pop_front()) : 'x, 32'(blk_word));
    blk_ready <= take;
  end
  // Model of one written byte; sends it and checks the acknowledge.
  task automatic wb(input logic [7:0] v);
    logic a;
    logic e;
    e = ph inside {[1:2]};
    case (ph)
      0:
      begin
        e = v[7:1] == own || v == 8'h10;
        exp_hs |= v[7:3] == 5'h01;
        ph = !e ? 4 : v[0] ? 5 : 1;
      end
      1:
      begin
        stk = first ? v[6] : stk;
        first = 1'b0;
        cmd = v;
        ph = 2;
      end
      2:
      begin
        hd = v;
        lh = v;
        ph = 3;
      end
      3:
      begin
        e = exp_q.size() < 2;
        ll = v;
        if (e)
        begin
          exp_q.push_back(ddac_block_t'({cmd[5:3], msk(cmd[2:0]), hd, v}));
          exp_ref = cmd[5:3] == 3'h7 ? v[0] : exp_ref;
        end
        ph = !e ? 4 : stk ? 2 : 1;
      end
      default:;
    endcase
    ddac_master_model_i.put_byte(v, a);
    chk("ack", 32'(e), 32'(a));
  endtask
  // Frame edges.
  task automatic st();
    ddac_master_model_i.start();
    ph = 0;
    first = 1'b1;
  endtask
  task automatic sp();
    ddac_master_model_i.stop();
    ph = 0;
    exp_hs = 1'b0;
  endtask
  // Command byte and two data bytes.
  task automatic blk3(input logic [7:0] c);
    wb(c);
    wb(8'(xs()));
    wb(c[5:3] == 3'h7 ? 8'h01 : 8'(xs()));
  endtask
  // Two-byte readback.
  task automatic rb();
    logic [7:0] b0, b1;
    st();
    wb({own, 1'b1});
    ddac_master_model_i.get_byte(1'b1, b0);
    ddac_master_model_i.get_byte(1'b0, b1);
    sp();
    chk("read", 32'({lh, ll}), 32'({b0, b1}));
  endtask
  // Waits for the consumer to take every expected block.
  task automatic drain();
    for (int n = 0; n < 400 && exp_q.size() != 0; n++)
      @(negedge clk);
    chk("drain", 0, exp_q.size());
  endtask
  // Main sequence.
  initial
  begin
    repeat (4) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    chk("idle", 32'h8, 32'({sda_oe_n, blk_valid, ref_enable, hs_active}));
    stall = 1'b0;
    for (int p = 0; p < 3; p++)
    begin
      pin = ddac_pin_t'(p);
      own = {5'h0f, p == 0 ? 2'b00 : p == 1 ? 2'b10 : 2'b11};
      for (int i = 0; i < 4; i++)
      begin
        st();
        wb(i == 0 ? 8'h00 : i == 1 ? 8'hf0 : i == 2 ? 8'h11 : {own ^ 7'h01, 1'b0});
        sp();
      end
      st();
      wb(p == 2 ? 8'h10 : {own, 1'b0});
      blk3(8'h00);
      sp();
    end
    st();
    wb({own, 1'b0});
    for (int k = 0; k < 8; k++)
      blk3({1'b0, k == 4, 3'(k), k[1] ? (k[0] ? 3'h3 : 3'h7) : {2'b00, k[0]}});
    sp();
    rb();
    chk("ref", 32'(exp_ref), 32'(ref_enable));
    st();
    wb({own, 1'b0});
    blk3(8'h5f);
    repeat (4) wb(8'(xs()));
    sp();
    st();
    wb({own, 1'b0});
    wb(8'h18);
    wb(8'ha5);
    sp();
    st();
    wb(8'h09);
    st();
    chk("hs", 32'(exp_hs), 32'(hs_active));
    wb({own, 1'b0});
    blk3(8'h18);
    sp();
    ddac_master_model_i.hold(8);
    chk("hs", 32'(exp_hs), 32'(hs_active));
    drain();
    stall = 1'b1;
    st();
    wb({own, 1'b0});
    repeat (3) blk3(8'h18);
    sp();
    stall = 1'b0;
    drain();
    final_report();
  end
endmodule
